// *** core/power_loss_ride_through.sv ***
// Main-supply interruption ride-through and undervoltage torque limiting.
//
// Function
// - Keep motor running through dropouts below hold time.
// - De-energise motor once dropout exceeds hold time.
// - Re-energise motor when main supply returns.
// - Drop servo-ready after hold time expires.
// - Control supply loss forces ordinary power-off.
// - Warn and limit current on low DC bus.
// - Mode selects off, host limit, internal limit.
// - Internal mode clamps torque to programmed percent.
// - Internal limit released after programmed release time.
// - Servo-off command cuts motor current at once.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "ride_through_cfg.svh"
module power_loss_ride_through #(
  parameter int unsigned CYCLES_PER_MS = `MS_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  // Supply monitors from the power stage, asynchronous.
  input  wire logic        main_supply_ok,
  input  wire logic        control_supply_ok,
  input  wire logic        dc_bus_low,
  // Drive outputs.
  output var  logic        motor_energise,
  output var  logic        servo_ready,
  output var  logic        undervoltage_warning,
  output var  logic [6:0]  torque_limit_pct,
  output var  logic        irq
);

  logic                          main_ok_s;              // Synchronised main supply good.
  logic                          ctrl_ok_s;              // Synchronised control supply good.
  logic                          dc_low_s;               // Synchronised DC bus low.
  ride_through_pkg::supply_state_t state_reg;            // Supply sequencing state.
  ride_through_pkg::supply_state_t state_next;           // Next sequencing state.
  ride_through_pkg::uv_mode_t    mode_active_reg;        // Mode in force since restart.
  logic [1:0]                    torque_limit_mode_select; // Mode written, pending restart.
  logic                          servo_on_reg;           // Host servo-on; clearing it is servo-off.
  logic                          restart_reg;            // One-cycle soft restart pulse.
  logic [15:0]                   power_cut_hold_time;    // Hold time in ms.
  logic [6:0]                    undervoltage_torque_limit; // Internal clamp in percent.
  logic [9:0]                    torque_limit_release_time; // Release time in ms.
  logic [6:0]                    host_limit_reg;         // Torque limit set by the host.
  logic [15:0]                   hold_ms_reg;            // Milliseconds spent in hold.
  logic [9:0]                    rel_ms_reg;             // Milliseconds spent releasing.
  logic                          rel_active_reg;         // Internal limit still releasing.
  logic                          hold_tick;              // Millisecond tick during hold.
  logic                          rel_tick;               // Millisecond tick during release.
  logic                          hold_done;              // Hold time has run out.
  logic                          rel_done;               // Release time has run out.
  logic                          uv_warn_next;           // Next undervoltage warning.
  logic                          limiting;               // Internal clamp in force.
  logic [6:0]                    limit_next;             // Next torque limit.
  logic [`IRQ_W-1:0]             irq_status_reg;         // Sticky event bits.
  logic [`IRQ_W-1:0]             irq_mask_reg;           // Interrupt enables.
  logic [`IRQ_W-1:0]             events;                 // Events seen this cycle.
  logic                          wr_pend_reg;            // Write data phase in progress.
  logic [7:0]                    wr_addr_reg;            // Offset of the pending write.
  logic                          rd_pend_reg;            // Read data phase awaiting data.
  logic [7:0]                    rd_addr_reg;            // Offset of the pending read.
  logic                          accept;                 // Address phase taken this edge.

  // Pins cross into the clock domain through two flops.
  sync_2ff #(
    .WIDTH (3)
  ) u_pin_sync (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .async_in ({main_supply_ok, control_supply_ok, dc_bus_low}),
    .sync_out ({main_ok_s, ctrl_ok_s, dc_low_s})
  );

  // Hold timer tick restarts its phase on every entry into hold.
  ms_tick_gen #(
    .CYCLES (CYCLES_PER_MS)
  ) u_hold_tick (
    .ref_clk (ref_clk),
    .srst    (srst),
    .clear   (state_reg != ride_through_pkg::ST_HOLD),
    .tick    (hold_tick)
  );

  // Release timer tick restarts its phase when a release begins.
  ms_tick_gen #(
    .CYCLES (CYCLES_PER_MS)
  ) u_rel_tick (
    .ref_clk (ref_clk),
    .srst    (srst),
    .clear   (!rel_active_reg),
    .tick    (rel_tick)
  );

  // Current settings are compared live, so new values act at once.
  assign hold_done = hold_tick && ((hold_ms_reg + 16'h0001) >= power_cut_hold_time);
  assign rel_done  = rel_tick && ((rel_ms_reg + 10'h001) >= torque_limit_release_time);

  // Supply sequencing.
  always_comb begin
    state_next = state_reg;
    if (!ctrl_ok_s) begin
      state_next = ride_through_pkg::ST_CTRL_LOST;
    end else if (restart_reg) begin
      state_next = ride_through_pkg::ST_OFF;
    end else begin
      case (state_reg)
        ride_through_pkg::ST_RUN: begin
          if (!main_ok_s) begin
            state_next = ride_through_pkg::ST_HOLD;
          end
        end
        ride_through_pkg::ST_HOLD: begin
          if (main_ok_s) begin
            state_next = ride_through_pkg::ST_RUN;
          end else if (hold_done) begin
            state_next = ride_through_pkg::ST_OFF;
          end
        end
        ride_through_pkg::ST_OFF: begin
          if (main_ok_s) begin
            state_next = ride_through_pkg::ST_RUN;
          end
        end
        ride_through_pkg::ST_CTRL_LOST: begin
          state_next = ride_through_pkg::ST_OFF;
        end
        default: begin
          state_next = ride_through_pkg::ST_OFF;
        end
      endcase
    end
  end

  // The state register; restart leaves the motor off until supply is seen.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= ride_through_pkg::ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Milliseconds spent in hold; cleared whenever hold is left.
  always_ff @(posedge ref_clk) begin
    if (srst || state_reg != ride_through_pkg::ST_HOLD) begin
      hold_ms_reg <= 16'h0000;
    end else if (hold_tick) begin
      hold_ms_reg <= hold_ms_reg + 16'h0001;
    end
  end

  // Motor power and servo-ready follow the next state so they switch with it.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      motor_energise <= 1'b0;
      servo_ready    <= 1'b0;
    end else begin
      // Servo-off drops current immediately, even inside a hold.
      motor_energise <= servo_on_reg && !restart_reg &&
                        (state_next == ride_through_pkg::ST_RUN ||
                         state_next == ride_through_pkg::ST_HOLD);
      servo_ready    <= (state_next == ride_through_pkg::ST_RUN ||
                         state_next == ride_through_pkg::ST_HOLD);
    end
  end

  // Warning exists only while a detecting mode is in force.
  assign uv_warn_next = (mode_active_reg == ride_through_pkg::MODE_HOST ||
                         mode_active_reg == ride_through_pkg::MODE_INTERNAL) &&
                        dc_low_s && !restart_reg;

  // Undervoltage warning output; the host acts on it in host mode.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      undervoltage_warning <= 1'b0;
    end else begin
      undervoltage_warning <= uv_warn_next;
    end
  end

  // Release phase after the warning clears in internal mode.
  always_ff @(posedge ref_clk) begin
    if (srst || restart_reg) begin
      rel_active_reg <= 1'b0;
      rel_ms_reg     <= 10'h000;
    end else if (uv_warn_next || rel_done || torque_limit_release_time == 10'h000) begin
      rel_active_reg <= 1'b0;
      rel_ms_reg     <= 10'h000;
    end else if (undervoltage_warning &&
                 mode_active_reg == ride_through_pkg::MODE_INTERNAL) begin
      rel_active_reg <= 1'b1;
      rel_ms_reg     <= 10'h000;
    end else if (rel_active_reg && rel_tick) begin
      rel_ms_reg <= rel_ms_reg + 10'h001;
    end
  end

  // Clamp is the lower of host limit and internal limit while it applies.
  assign limiting   = (mode_active_reg == ride_through_pkg::MODE_INTERNAL) &&
                      (undervoltage_warning || rel_active_reg);
  assign limit_next = (limiting && undervoltage_torque_limit < host_limit_reg) ?
                      undervoltage_torque_limit : host_limit_reg;

  // Torque limit output to the current loop.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      torque_limit_pct <= `HOST_LIMIT_RESET;
    end else begin
      torque_limit_pct <= limit_next;
    end
  end

  // Active mode is taken from the pending select only at restart.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mode_active_reg <= ride_through_pkg::MODE_OFF;
    end else if (restart_reg) begin
      mode_active_reg <= (torque_limit_mode_select == 2'h3) ?
                         ride_through_pkg::MODE_OFF :
                         ride_through_pkg::uv_mode_t'(torque_limit_mode_select);
    end
  end

  // Events for the interrupt logic.
  always_comb begin
    events = '0;
    events[`IRQ_DROP_BIT]    = state_reg == ride_through_pkg::ST_RUN &&
                               state_next == ride_through_pkg::ST_HOLD;
    events[`IRQ_EXPIRE_BIT]  = state_reg == ride_through_pkg::ST_HOLD &&
                               state_next == ride_through_pkg::ST_OFF;
    events[`IRQ_RESTORE_BIT] = state_reg != ride_through_pkg::ST_RUN &&
                               state_next == ride_through_pkg::ST_RUN;
    events[`IRQ_UV_SET_BIT]  = uv_warn_next && !undervoltage_warning;
    events[`IRQ_UV_CLR_BIT]  = !uv_warn_next && undervoltage_warning;
  end

  // Sticky status: a new event wins over a write-one clear.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_status_reg <= '0;
    end else if (wr_pend_reg && wr_addr_reg == `OFS_IRQ_STATUS) begin
      irq_status_reg <= (irq_status_reg & ~hwdata[`IRQ_W-1:0]) | events;
    end else begin
      irq_status_reg <= irq_status_reg | events;
    end
  end

  // Interrupt line is high while any enabled status bit is set.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Address phase is taken for any NONSEQ or SEQ transfer while the bus is ready.
  assign accept = hsel && htrans[1] && hready;

  // Bus phase tracking; reads take one wait state so data reflect prior writes.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      hrdata      <= 32'h0000_0000;
    end else begin
      hresp       <= 1'b0;
      wr_pend_reg <= accept && hwrite;
      rd_pend_reg <= accept && !hwrite;
      if (accept) begin
        wr_addr_reg <= {haddr[7:2], 2'b00};
        rd_addr_reg <= {haddr[7:2], 2'b00};
      end
      hreadyout <= !(accept && !hwrite);
      if (rd_pend_reg) begin
        hrdata <= read_mux(rd_addr_reg);
      end
    end
  end

  // Read data; unmapped offsets read as zero.
  function automatic logic [31:0] read_mux(input logic [7:0] ofs);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (ofs)
      `OFS_CTRL:         v = {26'h0, torque_limit_mode_select, 3'h0, servo_on_reg};
      `OFS_HOLD_TIME:    v = {16'h0000, power_cut_hold_time};
      `OFS_UV_LIMIT:     v = {25'h0, undervoltage_torque_limit};
      `OFS_RELEASE_TIME: v = {22'h0, torque_limit_release_time};
      `OFS_HOST_LIMIT:   v = {25'h0, host_limit_reg};
      `OFS_STATUS:       v = {16'h0, 1'b0, torque_limit_pct, mode_active_reg, state_reg,
                              limiting, undervoltage_warning, servo_ready, motor_energise};
      `OFS_IRQ_STATUS:   v = {27'h0, irq_status_reg};
      `OFS_IRQ_MASK:     v = {27'h0, irq_mask_reg};
      default:           v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // Register writes, committed in the data phase; out-of-range values saturate.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      servo_on_reg              <= 1'b0;
      restart_reg               <= 1'b0;
      torque_limit_mode_select  <= 2'h0;
      power_cut_hold_time       <= `HOLD_RESET;
      undervoltage_torque_limit <= `UV_LIMIT_RESET;
      torque_limit_release_time <= `REL_RESET;
      host_limit_reg            <= `HOST_LIMIT_RESET;
      irq_mask_reg              <= '0;
    end else begin
      restart_reg <= 1'b0;
      if (wr_pend_reg) begin
        case (wr_addr_reg)
          `OFS_CTRL: begin
            servo_on_reg             <= hwdata[`CTRL_SERVO_ON_BIT];
            restart_reg              <= hwdata[`CTRL_RESTART_BIT];
            torque_limit_mode_select <= hwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
          end
          `OFS_HOLD_TIME: begin
            power_cut_hold_time <= (hwdata[31:16] != 16'h0 || hwdata[15:0] > `HOLD_MAX) ?
                                   `HOLD_MAX : (hwdata[15:0] < `HOLD_MIN) ?
                                   `HOLD_MIN : hwdata[15:0];
          end
          `OFS_UV_LIMIT: begin
            undervoltage_torque_limit <= (hwdata[31:7] != 25'h0) ? `PCT_MAX :
                                         (hwdata[6:0] > `PCT_MAX) ? `PCT_MAX : hwdata[6:0];
          end
          `OFS_RELEASE_TIME: begin
            torque_limit_release_time <= (hwdata[31:10] != 22'h0) ? `REL_MAX :
                                         (hwdata[9:0] > `REL_MAX) ? `REL_MAX : hwdata[9:0];
          end
          `OFS_HOST_LIMIT: begin
            host_limit_reg <= (hwdata[31:7] != 25'h0) ? `PCT_MAX :
                              (hwdata[6:0] > `PCT_MAX) ? `PCT_MAX : hwdata[6:0];
          end
          `OFS_IRQ_MASK: begin
            irq_mask_reg <= hwdata[`IRQ_W-1:0];
          end
          default: begin
            irq_mask_reg <= irq_mask_reg;
          end
        endcase
      end
    end
  end

endmodule // power_loss_ride_through
`default_nettype wire

// *** core/ride_through_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the ride-through block.
`ifndef RIDE_THROUGH_CFG_SVH
`define RIDE_THROUGH_CFG_SVH

// Time base: one tick per millisecond at the 25 MHz reference clock.
`define CLK_FREQ_HZ          25000000
`define TICK_PERIOD_MS       1
`define MS_CYCLES            ((`CLK_FREQ_HZ / 1000) * `TICK_PERIOD_MS)
`define MS_CNT_W             16

// Register byte offsets.
`define OFS_CTRL             8'h00
`define OFS_HOLD_TIME        8'h04
`define OFS_UV_LIMIT         8'h08
`define OFS_RELEASE_TIME     8'h0C
`define OFS_HOST_LIMIT       8'h10
`define OFS_STATUS           8'h14
`define OFS_IRQ_STATUS       8'h18
`define OFS_IRQ_MASK         8'h1C

// Control register fields.
`define CTRL_SERVO_ON_BIT    0
`define CTRL_RESTART_BIT     1
`define CTRL_MODE_LSB        4
`define CTRL_MODE_MSB        5

// Setting ranges and reset values.
`define HOLD_MIN             16'h0014
`define HOLD_MAX             16'hC350
`define HOLD_RESET           16'h0014
`define PCT_MAX              7'h64
`define UV_LIMIT_RESET       7'h32
`define REL_MAX              10'h3E8
`define REL_RESET            10'h064
`define HOST_LIMIT_RESET     7'h64

// Interrupt event bit positions.
`define IRQ_W                5
`define IRQ_DROP_BIT         0
`define IRQ_EXPIRE_BIT       1
`define IRQ_RESTORE_BIT      2
`define IRQ_UV_SET_BIT       3
`define IRQ_UV_CLR_BIT       4

`endif

// *** core/ride_through_pkg.sv ***
// Types shared by the ride-through block.
package ride_through_pkg;

  // Supply sequencing states.
  typedef enum logic [1:0] {
    ST_RUN       = 2'b00,
    ST_HOLD      = 2'b01,
    ST_OFF       = 2'b10,
    ST_CTRL_LOST = 2'b11
  } supply_state_t;

  // Undervoltage torque-limit modes.
  typedef enum logic [1:0] {
    MODE_OFF      = 2'b00,
    MODE_HOST     = 2'b01,
    MODE_INTERNAL = 2'b10,
    MODE_RSVD     = 2'b11
  } uv_mode_t;

endpackage

// *** core/sync_2ff.sv ***
// Two-flop synchroniser for a group of asynchronous pin inputs.
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;  // First stage, read only by the second stage.

  // Two back-to-back flops give metastability time to settle.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // sync_2ff
`default_nettype wire

// *** core/ms_tick_gen.sv ***
// Millisecond tick generator with a phase clear.
`timescale 1ns/100ps
`default_nettype none
`include "ride_through_cfg.svh"
module ms_tick_gen #(
  parameter int unsigned CYCLES = `MS_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic clear,
  output var  logic tick
);

  logic [`MS_CNT_W-1:0] cnt_reg;  // Cycles elapsed in the current millisecond.

  // Counts clock cycles; the clear restarts the phase so the first tick
  // comes exactly one millisecond after the clear is released.
  always_ff @(posedge ref_clk) begin
    if (srst || clear) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else if (cnt_reg == `MS_CNT_W'(CYCLES - 1)) begin
      cnt_reg <= '0;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + `MS_CNT_W'(1);
      tick    <= 1'b0;
    end
  end

endmodule // ms_tick_gen
`default_nettype wire

// *** testbench/ride_through_assertions.sv ***
// Checker for the ride-through block, watching its ports only.
`timescale 1ns/100ps
`default_nettype none
module ride_through_checker #(
  parameter int unsigned CYCLES_PER_MS = 10
) (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        main_supply_ok,
  input wire logic        control_supply_ok,
  input wire logic        dc_bus_low,
  input wire logic        motor_energise,
  input wire logic        servo_ready,
  input wire logic        undervoltage_warning,
  input wire logic [6:0]  torque_limit_pct
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  logic [15:0] main_lo_cnt; // Cycles the main supply pin has been low, saturating.
  logic        wr_ctrl_dp;  // High in the data phase of a control word write.
  // Measure the dropout length so an early servo-ready drop is caught.
  always_ff @(posedge ref_clk) begin
    if (srst || main_supply_ok) begin
      main_lo_cnt <= 16'h0000;
    end else if (main_lo_cnt != 16'hFFFF) begin
      main_lo_cnt <= main_lo_cnt + 16'h0001;
    end
  end
  // Track control word writes so the servo-off bit can be seen in its data phase.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_ctrl_dp <= 1'b0;
    end else if (hready) begin
      wr_ctrl_dp <= hsel && htrans[1] && hwrite && (haddr[7:2] == 6'h00);
    end
  end
  chk_ctrl_loss_off: assert property (
    !control_supply_ok [*4] |-> !motor_energise && !servo_ready)
    else $error("drive stayed on without control supply");
  chk_hold_expiry: assert property (
    $fell(servo_ready) |-> !control_supply_ok || main_lo_cnt > 20 * CYCLES_PER_MS)
    else $error("servo ready dropped before hold time");
  chk_restore_ready: assert property (
    (main_supply_ok && control_supply_ok) [*6] |-> servo_ready)
    else $error("servo ready missing with both supplies good");
  chk_motor_needs_ready: assert property (
    motor_energise |-> servo_ready)
    else $error("motor energised while not ready");
  chk_servo_off_cut: assert property (
    wr_ctrl_dp && !hwdata[0] |-> ##2 !motor_energise)
    else $error("servo off did not cut motor current");
  chk_uv_warn_clear: assert property (
    !dc_bus_low [*4] |-> !undervoltage_warning)
    else $error("warning without low bus");
  chk_limit_range: assert property (
    torque_limit_pct <= 7'h64)
    else $error("torque limit above rated");
  chk_read_wait: assert property (
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
endmodule // ride_through_checker
bind power_loss_ride_through ride_through_checker #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_chk (
  .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .main_supply_ok(main_supply_ok), .control_supply_ok(control_supply_ok),
  .dc_bus_low(dc_bus_low), .motor_energise(motor_energise), .servo_ready(servo_ready),
  .undervoltage_warning(undervoltage_warning), .torque_limit_pct(torque_limit_pct));
`default_nettype wire

// *** testbench/host_ctrl_model.sv ***
// Host controller model that clamps torque around the undervoltage warning.
`timescale 1ns/100ps
`default_nettype none
module host_ctrl_model #(
  parameter logic [6:0] HOST_CAP = 7'h28
) (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       undervoltage_warning,
  output var  logic [6:0] host_limit_req
);
  // Clamp only while the warning stands; full torque is requested again the cycle after it clears.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      host_limit_req <= 7'h64;
    end else if (undervoltage_warning) begin
      host_limit_req <= HOST_CAP;
    end else begin
      host_limit_req <= 7'h64;
    end
  end
endmodule // host_ctrl_model
`default_nettype wire

// *** testbench/power_loss_ride_through_tb.sv ***
// Self-checking bench for the ride-through block.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module power_loss_ride_through_tb;
  localparam int unsigned CPM = 10; // Clock cycles per simulated millisecond.
  logic ref_clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'b00;
  logic        hreadyout, hresp, motor_energise, servo_ready, undervoltage_warning, irq;
  logic        main_supply_ok = 1'b1, control_supply_ok = 1'b1, dc_bus_low = 1'b0;
  logic [6:0]  torque_limit_pct, host_limit_req, hl;
  int          miscompares = 0, n_compared = 0;
  assign hready = hreadyout;
  always #20 ref_clk = ~ref_clk;
  power_loss_ride_through #(.CYCLES_PER_MS(CPM)) dut (.ref_clk(ref_clk), .srst(srst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .main_supply_ok(main_supply_ok), .control_supply_ok(control_supply_ok),
    .dc_bus_low(dc_bus_low), .motor_energise(motor_energise), .servo_ready(servo_ready),
    .undervoltage_warning(undervoltage_warning), .torque_limit_pct(torque_limit_pct),
    .irq(irq));
  host_ctrl_model host (.ref_clk(ref_clk), .srst(srst),
    .undervoltage_warning(undervoltage_warning), .host_limit_req(host_limit_req));
  // Expected torque limit: internal mode clamps to the lower of the two limits.
  function automatic logic [6:0] exp_lim(input int m, input logic [6:0] uv, input logic [6:0] h);
    return (m == 2 && uv < h) ? uv : h;
  endfunction
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One single AHB-Lite transfer; waits on hready under a bound.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int t;
    t = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge ref_clk);
    while (hready !== 1'b1 && t < 50) begin @(posedge ref_clk); t++; end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge ref_clk);
    while (hready !== 1'b1 && t < 50) begin @(posedge ref_clk); t++; end
    q = hrdata;
    if (t >= 50) begin miscompares++; tally_and_finish(); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHECK("register", e, q)
    `CHECK("hresp", 1'b0, hresp)
  endtask
  // Main sequence: reset, dropouts, control loss, then every limit mode.
  initial begin
    int n, m, hold, rel;
    logic [6:0] uvl;
    void'($urandom(32'hA221E2FA));
    hl = 7'h64;
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rdc(8'h08, 32'h32);
    rdc(8'h0C, 32'h64);
    rdc(8'h20, 32'h0);
    wr(8'h04, 32'h0);
    rdc(8'h04, 32'h14);
    `CHECK("limit", 7'h64, torque_limit_pct)
    wr(8'h00, 32'h1);
    wr(8'h1C, 32'h2);
    repeat (8) @(posedge ref_clk);
    n = 20 + $urandom_range(170);
    main_supply_ok <= 1'b0;
    repeat (n) begin @(posedge ref_clk); `CHECK("run", 2'b11, {motor_energise, servo_ready}) end
    main_supply_ok <= 1'b1;
    hold = 20 + $urandom_range(20);
    wr(8'h04, 32'(hold));
    repeat (6) @(posedge ref_clk);
    main_supply_ok <= 1'b0;
    n = 0;
    while (servo_ready === 1'b1 && n < 1000) begin @(posedge ref_clk); n++; end
    `CHECK("expiry", 1'b1, n >= hold * CPM && n <= hold * CPM + 6)
    `CHECK("motor", 1'b0, motor_energise)
    @(posedge ref_clk);
    `CHECK("irq", 1'b1, irq)
    wr(8'h1C, 32'h0);
    repeat (2) @(posedge ref_clk);
    `CHECK("irq", 1'b0, irq)
    wr(8'h18, 32'h1F);
    wr(8'h1C, 32'h2);
    repeat (2) @(posedge ref_clk);
    `CHECK("irq", 1'b0, irq)
    main_supply_ok <= 1'b1;
    repeat (6) @(posedge ref_clk);
    `CHECK("motor", 1'b1, motor_energise)
    wr(8'h04, 32'h3E8);
    for (m = 0; m < 3; m++) begin
      control_supply_ok <= 1'b0;
      repeat (5) @(posedge ref_clk);
      `CHECK("off", 2'b00, {motor_energise, servo_ready})
      wr(8'h00, 32'h3 | 32'(m << 4));
      wr(8'h00, 32'h1 | 32'(((m + 1) % 3) << 4));
      uvl = 7'($urandom_range(99));
      rel = 1 + $urandom_range(4);
      wr(8'h08, {25'h0, uvl});
      wr(8'h0C, 32'(rel));
      control_supply_ok <= 1'b1;
      repeat (8) @(posedge ref_clk);
      dc_bus_low <= 1'b1;
      repeat (5) @(posedge ref_clk);
      `CHECK("warning", m != 0, undervoltage_warning)
      if (m == 1) begin
        hl = host_limit_req;
        wr(8'h10, {25'h0, hl});
      end
      repeat (3) @(posedge ref_clk);
      `CHECK("limit", exp_lim(m, uvl, hl), torque_limit_pct)
      dc_bus_low <= 1'b0;
      n = 0;
      while (torque_limit_pct !== 7'h64 && n < 200) begin
        @(posedge ref_clk);
        n++;
        if (m == 1 && undervoltage_warning === 1'b0) begin
          hl = host_limit_req;
          wr(8'h10, {25'h0, hl});
        end
      end
      `CHECK("release", 1'b1, m != 2 || (n >= rel * CPM && n <= rel * CPM + 8))
    end
    wr(8'h00, 32'h0);
    repeat (2) @(posedge ref_clk);
    `CHECK("motor", 1'b0, motor_energise)
    tally_and_finish();
  end
endmodule // power_loss_ride_through_tb
`default_nettype wire
